// ---- logic/clock_ctrl_pkg.sv ----
package clock_ctrl_pkg;

  // ****************************************************************
  // Register indices; the byte address on the bus is four times these.
  // ****************************************************************
  localparam logic [15:0] IDX_INTERNAL_OSC_CONTROL       = 16'h50C0;
  localparam logic [15:0] IDX_EXTERNAL_OSC_CONTROL       = 16'h50C1;
  localparam logic [15:0] IDX_PERIPHERAL_CLOCK_GATE_FIRST = 16'h50C7;
  localparam logic [15:0] IDX_CLOCK_SWITCH_CONTROL       = 16'h50C8;
  localparam int          ADR_W                          = 18;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] RST_INTERNAL_OSC_CONTROL = 8'h01;
  localparam logic [7:0] RST_EXTERNAL_OSC_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPH_GATE          = 8'hFF;
  localparam logic [7:0] RST_SWITCH_CONTROL       = 8'h03;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int ICTL_FAST_EN   = 0;
  localparam int ICTL_FAST_RDY  = 1;
  localparam int ICTL_SLOW_RDY  = 4;
  localparam int ECTL_XTAL_EN   = 0;
  localparam int ECTL_XTAL_RDY  = 1;
  localparam int SW_REQ_LO      = 0;
  localparam int SW_CUR_LO      = 2;
  localparam int SW_MON_EN      = 4;
  localparam int SW_FAIL        = 5;
  localparam int GATE_TIMER_ONE            = 7;
  localparam int GATE_TIMER_THREE          = 6;
  localparam int GATE_TIMER_TWO            = 5;
  localparam int GATE_TIMER_FOUR           = 4;
  localparam int GATE_LIN_SERIAL           = 3;
  localparam int GATE_SYNC_ASYNC_SERIAL    = 2;
  localparam int GATE_SPI                  = 1;
  localparam int GATE_I2C                  = 0;

  // ****************************************************************
  // Source codes as software sees them.
  // ****************************************************************
  localparam logic [1:0] CODE_FAST     = 2'h0;
  localparam logic [1:0] CODE_SLOW     = 2'h1;
  localparam logic [1:0] CODE_XTAL     = 2'h2;
  localparam logic [1:0] CODE_FALLBACK = 2'h3;

  typedef enum logic [3:0] {
    SRC_FAST     = 4'b0001,
    SRC_SLOW     = 4'b0010,
    SRC_XTAL     = 4'b0100,
    SRC_FALLBACK = 4'b1000
  } source_t;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CORE_CLK_KHZ       = 200000;
  localparam int SLOW_OSC_KHZ       = 128;
  localparam int FAST_OSC_KHZ       = 16000;
  localparam int FALLBACK_DIVIDE    = 8;
  localparam int XTAL_MIN_KHZ       = 1000;
  localparam int XTAL_MAX_KHZ       = 24000;
  localparam int SLOW_DIV_CYCLES    = CORE_CLK_KHZ / SLOW_OSC_KHZ;
  localparam int FAST_DIV_CYCLES    = CORE_CLK_KHZ / FAST_OSC_KHZ;
  localparam int XTAL_TIMEOUT_CYCLES = 2 * ((CORE_CLK_KHZ + XTAL_MIN_KHZ - 1) / XTAL_MIN_KHZ);

endpackage

// ---- logic/clock_control.sv ----
`timescale 1ns/100ps
// Functional notes
// - A slow internal oscillator tick runs at 128 kHz independent of the selected system source.
// - The slow oscillator tick clocks the watchdog and the auto wakeup timer.
// - The slow oscillator may become the system clock only when the option byte allows it.
// - The crystal oscillator, 1 to 24 MHz, may be selected as the system clock source.
// - A detected crystal failure raises an interrupt.
// - A detected crystal failure switches the system clock to the fast internal oscillator over eight.
// - Gate bits 7..0 map to timer one, three, two, four, LIN serial, USART, SPI and I2C.
module clock_control (
  input  wire logic                                core_clk,
  input  wire logic                                rst_n,
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [clock_ctrl_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]                          wb_sel_i,
  input  wire logic [31:0]                         wb_dat_i,
  output logic      [31:0]                         wb_dat_o,
  output logic                                     wb_ack_o,
  input  wire logic                                osc_input_pin,
  input  wire logic                                slow_osc_sysclk_allow,
  output logic                                     sys_clk_en,
  output logic      [3:0]                          sys_source,
  output logic                                     watchdog_clk_en,
  output logic                                     auto_wakeup_clk_en,
  output logic      [7:0]                          periph_clk_en,
  output logic                                     clock_failure_irq
);

  // ****************************************************************
  // Oscillator dividers.
  // ****************************************************************
  localparam logic [10:0] SLOW_LAST = 11'(clock_ctrl_pkg::SLOW_DIV_CYCLES - 1);
  localparam logic [3:0]  FAST_LAST = 4'(clock_ctrl_pkg::FAST_DIV_CYCLES - 1);
  localparam logic [2:0]  FB_LAST   = 3'(clock_ctrl_pkg::FALLBACK_DIVIDE - 1);
  localparam logic [9:0]  XTAL_TMO  = 10'(clock_ctrl_pkg::XTAL_TIMEOUT_CYCLES);

  if (clock_ctrl_pkg::SLOW_DIV_CYCLES > 2048 || clock_ctrl_pkg::FAST_DIV_CYCLES > 16 ||
      clock_ctrl_pkg::XTAL_TIMEOUT_CYCLES > 1023 || clock_ctrl_pkg::FAST_DIV_CYCLES < 1) begin : g_div_fit
    $error("clock_control: divider constants do not fit the counters");
  end

  logic [10:0] slow_cnt;
  logic        slow_tick;
  logic [3:0]  fast_cnt;
  logic        fast_tick;
  logic [2:0]  fb_cnt;
  logic        fb_tick;
  logic        fast_en;
  logic        fast_run;
  clock_ctrl_pkg::source_t cur_src;

  // The slow oscillator never stops, so the watchdog keeps counting whatever the system source does.
  assign slow_tick = (slow_cnt == SLOW_LAST);
  assign fast_run  = fast_en || cur_src == clock_ctrl_pkg::SRC_FAST || cur_src == clock_ctrl_pkg::SRC_FALLBACK;
  assign fast_tick = fast_run && (fast_cnt == FAST_LAST);
  assign fb_tick   = fast_tick && (fb_cnt == FB_LAST);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt <= 11'h000;
      fast_cnt <= 4'h0;
      fb_cnt   <= 3'h0;
      watchdog_clk_en    <= 1'b0;
      auto_wakeup_clk_en <= 1'b0;
    end else begin
      slow_cnt <= slow_tick ? 11'h000 : slow_cnt + 11'h001;
      if (fast_run)
        fast_cnt <= (fast_cnt == FAST_LAST) ? 4'h0 : fast_cnt + 4'h1;
      if (fast_tick)
        fb_cnt <= fb_cnt + 3'h1;
      watchdog_clk_en    <= slow_tick;
      auto_wakeup_clk_en <= slow_tick;
    end
  end

  // ****************************************************************
  // Crystal input: synchroniser, edge detect and activity timeout.
  // ****************************************************************
  logic       xtal_s1;
  logic       xtal_s2;
  logic       xtal_s3;
  logic       xtal_edge;
  logic [9:0] xtal_idle;
  logic       xtal_seen;
  logic       xtal_en;
  logic       xtal_rdy;
  logic       xtal_lost;

  assign xtal_edge = xtal_s2 && !xtal_s3;
  assign xtal_lost = (xtal_idle == XTAL_TMO);
  assign xtal_rdy  = xtal_en && xtal_seen && !xtal_lost;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_s1   <= 1'b0;
      xtal_s2   <= 1'b0;
      xtal_s3   <= 1'b0;
      xtal_idle <= 10'h000;
      xtal_seen <= 1'b0;
    end else begin
      xtal_s1 <= osc_input_pin;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
      if (!xtal_en || xtal_edge)
        xtal_idle <= 10'h000;
      else if (!xtal_lost)
        xtal_idle <= xtal_idle + 10'h001;
      xtal_seen <= xtal_en && (xtal_seen || xtal_edge);
    end
  end

  // ****************************************************************
  // Wishbone slave and registers.
  // ****************************************************************
  logic       req;
  logic       wr_now;
  logic [15:0] idx;
  logic       hit_ictl;
  logic       hit_ectl;
  logic       hit_gate;
  logic       hit_sw;
  logic [7:0] gate;
  logic       mon_en;
  logic       fail_flag;
  logic       allow_q;
  logic       allow_loaded;
  logic [1:0] cur_code;
  logic [7:0] rd_byte;
  logic       fail_event;
  logic       sw_write;
  logic [1:0] sw_req;
  logic       req_legal;

  assign req      = wb_cyc_i && wb_stb_i;
  assign idx      = wb_adr_i[17:2];
  assign hit_ictl = (idx == clock_ctrl_pkg::IDX_INTERNAL_OSC_CONTROL);
  assign hit_ectl = (idx == clock_ctrl_pkg::IDX_EXTERNAL_OSC_CONTROL);
  assign hit_gate = (idx == clock_ctrl_pkg::IDX_PERIPHERAL_CLOCK_GATE_FIRST);
  assign hit_sw   = (idx == clock_ctrl_pkg::IDX_CLOCK_SWITCH_CONTROL);
  assign wr_now   = req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign sw_write = wr_now && hit_sw;
  assign sw_req   = wb_dat_i[clock_ctrl_pkg::SW_REQ_LO +: 2];

  function automatic logic [1:0] encode_source(input clock_ctrl_pkg::source_t s);
    case (s)
      clock_ctrl_pkg::SRC_FAST:     encode_source = clock_ctrl_pkg::CODE_FAST;
      clock_ctrl_pkg::SRC_SLOW:     encode_source = clock_ctrl_pkg::CODE_SLOW;
      clock_ctrl_pkg::SRC_XTAL:     encode_source = clock_ctrl_pkg::CODE_XTAL;
      default:                      encode_source = clock_ctrl_pkg::CODE_FALLBACK;
    endcase
  endfunction

  assign cur_code = encode_source(cur_src);
  assign rd_byte  = hit_ictl ? {3'b000, 1'b1, 2'b00, fast_run, fast_en} :
                    hit_ectl ? {6'b000000, xtal_rdy, xtal_en} :
                    hit_gate ? gate :
                    hit_sw   ? {2'b00, fail_flag, mon_en, cur_code, cur_code} : 8'h00;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o)
        wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_en <= clock_ctrl_pkg::RST_INTERNAL_OSC_CONTROL[clock_ctrl_pkg::ICTL_FAST_EN];
      xtal_en <= clock_ctrl_pkg::RST_EXTERNAL_OSC_CONTROL[clock_ctrl_pkg::ECTL_XTAL_EN];
      gate    <= clock_ctrl_pkg::RST_PERIPH_GATE;
      mon_en  <= clock_ctrl_pkg::RST_SWITCH_CONTROL[clock_ctrl_pkg::SW_MON_EN];
    end else begin
      if (wr_now && hit_ictl)
        fast_en <= wb_dat_i[clock_ctrl_pkg::ICTL_FAST_EN];
      if (wr_now && hit_ectl)
        xtal_en <= wb_dat_i[clock_ctrl_pkg::ECTL_XTAL_EN];
      if (wr_now && hit_gate)
        gate <= wb_dat_i[7:0];
      if (sw_write)
        mon_en <= wb_dat_i[clock_ctrl_pkg::SW_MON_EN];
    end
  end

  // The option byte level is caught once, after reset has released.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      allow_q      <= 1'b0;
      allow_loaded <= 1'b0;
    end else if (!allow_loaded) begin
      allow_q      <= slow_osc_sysclk_allow;
      allow_loaded <= 1'b1;
    end
  end

  // ****************************************************************
  // Source switch and failure monitor.
  // ****************************************************************
  assign fail_event = mon_en && xtal_en && cur_src == clock_ctrl_pkg::SRC_XTAL && xtal_lost;
  assign req_legal  = (sw_req == clock_ctrl_pkg::CODE_FAST && fast_en) ||
                      (sw_req == clock_ctrl_pkg::CODE_SLOW && allow_q) ||
                      (sw_req == clock_ctrl_pkg::CODE_XTAL && xtal_rdy) ||
                      (sw_req == clock_ctrl_pkg::CODE_FALLBACK);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_src   <= clock_ctrl_pkg::SRC_FALLBACK;
      fail_flag <= 1'b0;
    end else begin
      // A failure outranks a software switch issued in the same cycle, and its flag wins over the clear.
      if (fail_event)
        cur_src <= clock_ctrl_pkg::SRC_FALLBACK;
      else if (sw_write && req_legal) begin
        case (sw_req)
          clock_ctrl_pkg::CODE_FAST: cur_src <= clock_ctrl_pkg::SRC_FAST;
          clock_ctrl_pkg::CODE_SLOW: cur_src <= clock_ctrl_pkg::SRC_SLOW;
          clock_ctrl_pkg::CODE_XTAL: cur_src <= clock_ctrl_pkg::SRC_XTAL;
          default:                   cur_src <= clock_ctrl_pkg::SRC_FALLBACK;
        endcase
      end
      if (fail_event)
        fail_flag <= 1'b1;
      else if (sw_write && wb_dat_i[clock_ctrl_pkg::SW_FAIL])
        fail_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // System tick and peripheral gates.
  // ****************************************************************
  logic sel_tick;

  assign sel_tick = (cur_src == clock_ctrl_pkg::SRC_FAST     && fast_tick) ||
                    (cur_src == clock_ctrl_pkg::SRC_SLOW     && slow_tick) ||
                    (cur_src == clock_ctrl_pkg::SRC_XTAL     && xtal_edge) ||
                    (cur_src == clock_ctrl_pkg::SRC_FALLBACK && fb_tick);

  // Gating a one-cycle enable rather than a clock wire cannot produce a runt pulse.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_clk_en    <= 1'b0;
      periph_clk_en <= 8'h00;
    end else begin
      sys_clk_en    <= sel_tick;
      periph_clk_en <= gate & {8{sel_tick}};
    end
  end

  assign sys_source        = cur_src;
  assign clock_failure_irq = fail_flag;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic [10:0] gap;
  logic        gap_valid;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap       <= 11'h000;
      gap_valid <= 1'b0;
    end else begin
      gap       <= slow_tick ? 11'h000 : gap + 11'h001;
      gap_valid <= gap_valid || slow_tick;
    end
  end

  sequence sw_to_xtal_s;
    sw_write && sw_req == clock_ctrl_pkg::CODE_XTAL && xtal_rdy && !fail_event;
  endsequence
  sequence fail_s;
    fail_event;
  endsequence

  slow_period_a: assert property (slow_tick && gap_valid |-> gap == SLOW_LAST)
    else $error("slow oscillator tick period wrong");
  watchdog_feed_a: assert property (slow_tick |=> watchdog_clk_en && auto_wakeup_clk_en)
    else $error("watchdog or wakeup timer missed slow tick");
  slow_allowed_a: assert property (cur_src == clock_ctrl_pkg::SRC_SLOW |-> allow_q)
    else $error("slow source selected without option permission");
  xtal_select_a: assert property (sw_to_xtal_s |=> cur_src == clock_ctrl_pkg::SRC_XTAL)
    else $error("crystal selection not taken");
  fail_irq_a: assert property (fail_s |=> clock_failure_irq ##1 (clock_failure_irq || $past(sw_write)))
    else $error("failure did not raise interrupt");
  fail_fallback_a: assert property (fail_s |=> sys_source == clock_ctrl_pkg::SRC_FALLBACK)
    else $error("failure did not switch to fallback");
  timer_one_gate_a: assert property (periph_clk_en[clock_ctrl_pkg::GATE_TIMER_ONE]
                                     |-> $past(gate[7]) && $past(sel_tick))
    else $error("timer one clock without its gate bit");
  gate_stop_a: assert property ((periph_clk_en & ~$past(gate)) == 8'h00 && (periph_clk_en == 8'h00 || sys_clk_en))
    else $error("peripheral clock ran while gated");
  monitor_scope_a: assert property ($rose(fail_flag) |-> $past(xtal_en) && $past(mon_en)
                                    && $past(cur_src) == clock_ctrl_pkg::SRC_XTAL)
    else $error("failure flagged outside crystal operation");

endmodule

// ---- testbench/xtal_source.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Crystal or external clock on the oscillator input.
// ****************************************************************
module xtal_source #(
  parameter real HALF_NS = 40.0
) (
  input  wire logic run,
  output logic      osc_input_pin
);
  // A stopped resonator leaves the pin at rest, which is the failure the monitor must see.
  // The default half period gives 12.5 MHz, inside the legal band.
  initial begin
    osc_input_pin = 1'b0;
    forever begin
      #(HALF_NS);
      osc_input_pin = run ? ~osc_input_pin : 1'b0;
    end
  end
endmodule

// ---- testbench/clock_source_select_and_gating_tb.sv ----
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, (got), (exp)); end end
module clock_source_select_and_gating_tb;
  logic        core_clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        allow;
  logic        xtal_run;
  logic [17:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        sys_tick;
  logic        wdt;
  logic        wake_en;
  logic        irq;
  logic        osc_pin;
  logic [3:0]  src;
  logic [7:0]  pen;
  logic [7:0]  rd;
  int          n;
  int          num_errors  = 0;
  int          checks_done = 0;

  clock_control uut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .osc_input_pin(osc_pin), .slow_osc_sysclk_allow(allow), .sys_clk_en(sys_tick), .sys_source(src),
    .watchdog_clk_en(wdt), .auto_wakeup_clk_en(wake_en), .periph_clk_en(pen), .clock_failure_irq(irq));
  xtal_source xtal (.run(xtal_run), .osc_input_pin(osc_pin));

  always #2.5 core_clk = ~core_clk;

  // ****************************************************************
  // Shared helpers.
  // ****************************************************************
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task give_up;
    num_errors++;
    $display("BAD t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    tally_and_finish();
  endtask

  task do_reset(input logic allow_v);
    rst_n <= 1'b0;
    allow <= allow_v;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask

  task wb(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic s0);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    sel  <= {3'b111, s0};
    wdat <= {24'h00_0000, d};
    n = 0;
    do begin @(posedge core_clk); n++; end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) give_up();
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge core_clk);
  endtask

  // Leaves n as the number of edges since the previous tick.
  task next_tick;
    n = 0;
    do begin @(posedge core_clk); n++; end while (sys_tick !== 1'b1 && n < 2000);
    if (n >= 2000) give_up();
  endtask

  task next_wdt;
    n = 0;
    do begin @(posedge core_clk); n++; end while (wdt !== 1'b1 && n < 2000);
    if (n >= 2000) give_up();
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task t_regs;
    wb(0, clock_ctrl_pkg::IDX_EXTERNAL_OSC_CONTROL, 8'h00, 1);
    `CHK(rd, clock_ctrl_pkg::RST_EXTERNAL_OSC_CONTROL)
    `CHK(rdat[31:8], 24'h00_0000)
    wb(0, clock_ctrl_pkg::IDX_PERIPHERAL_CLOCK_GATE_FIRST, 8'h00, 1);
    `CHK(rd, clock_ctrl_pkg::RST_PERIPH_GATE)
    wb(0, clock_ctrl_pkg::IDX_INTERNAL_OSC_CONTROL, 8'h00, 1);
    `CHK(rd[0], 1'b1)
    `CHK(src, clock_ctrl_pkg::SRC_FALLBACK)
    wb(1, 16'h50C2, 8'hA5, 1);
    wb(0, 16'h50C2, 8'h00, 1);
    `CHK(rd, 8'h00)
    wb(1, clock_ctrl_pkg::IDX_PERIPHERAL_CLOCK_GATE_FIRST, 8'h00, 0);
    wb(0, clock_ctrl_pkg::IDX_PERIPHERAL_CLOCK_GATE_FIRST, 8'h00, 1);
    `CHK(rd, clock_ctrl_pkg::RST_PERIPH_GATE)
    wb(1, clock_ctrl_pkg::IDX_EXTERNAL_OSC_CONTROL, 8'h02, 1);
    wb(0, clock_ctrl_pkg::IDX_EXTERNAL_OSC_CONTROL, 8'h00, 1);
    `CHK(rd, 8'h00)
    wb(1, clock_ctrl_pkg::IDX_CLOCK_SWITCH_CONTROL, 8'h01, 1);
    `CHK(src, clock_ctrl_pkg::SRC_FALLBACK)
    $display("register test done");
  endtask

  task t_wdt;
    next_wdt();
    next_wdt();
    `CHK(n, clock_ctrl_pkg::SLOW_DIV_CYCLES)
    `CHK(wake_en, 1'b1)
    $display("slow tick test done");
  endtask

  task t_gate;
    logic [7:0] g;
    wb(1, clock_ctrl_pkg::IDX_CLOCK_SWITCH_CONTROL, 8'h00, 1);
    `CHK(src, clock_ctrl_pkg::SRC_FAST)
    for (int i = 0; i < 9; i++) begin
      g = (i == 8) ? 8'h00 : (8'h01 << i);
      wb(1, clock_ctrl_pkg::IDX_PERIPHERAL_CLOCK_GATE_FIRST, g, 1);
      next_tick();
      `CHK(pen, g)
    end
    $display("gate test done");
  endtask

  task t_slow;
    do_reset(1'b1);
    wb(1, clock_ctrl_pkg::IDX_CLOCK_SWITCH_CONTROL, 8'h01, 1);
    `CHK(src, clock_ctrl_pkg::SRC_SLOW)
    next_tick();
    next_tick();
    `CHK(n, clock_ctrl_pkg::SLOW_DIV_CYCLES)
    $display("slow source test done");
  endtask

  task t_xtal;
    wb(1, clock_ctrl_pkg::IDX_EXTERNAL_OSC_CONTROL, 8'h01, 1);
    xtal_run <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      wb(0, clock_ctrl_pkg::IDX_EXTERNAL_OSC_CONTROL, 8'h00, 1);
      if (rd[1] === 1'b1) break;
    end
    `CHK(rd, 8'h03)
    wb(1, clock_ctrl_pkg::IDX_CLOCK_SWITCH_CONTROL, 8'h12, 1);
    `CHK(src, clock_ctrl_pkg::SRC_XTAL)
    xtal_run <= 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin @(posedge core_clk); n++; end
    `CHK(irq, 1'b1)
    `CHK(src, clock_ctrl_pkg::SRC_FALLBACK)
    `CHK(n > clock_ctrl_pkg::XTAL_TIMEOUT_CYCLES - 20 && n < clock_ctrl_pkg::XTAL_TIMEOUT_CYCLES + 20, 1'b1)
    next_tick();
    next_tick();
    `CHK(n, clock_ctrl_pkg::FAST_DIV_CYCLES * clock_ctrl_pkg::FALLBACK_DIVIDE)
    wb(0, clock_ctrl_pkg::IDX_CLOCK_SWITCH_CONTROL, 8'h00, 1);
    `CHK(rd, 8'h3F)
    wb(1, clock_ctrl_pkg::IDX_CLOCK_SWITCH_CONTROL, 8'h33, 1);
    `CHK(irq, 1'b0)
    // The crystal stays enabled and dead; an unselected crystal must not trip the monitor.
    wb(1, clock_ctrl_pkg::IDX_CLOCK_SWITCH_CONTROL, 8'h10, 1);
    `CHK(src, clock_ctrl_pkg::SRC_FAST)
    repeat (600) @(posedge core_clk);
    `CHK(irq, 1'b0)
    `CHK(src, clock_ctrl_pkg::SRC_FAST)
    $display("crystal failure test done");
  endtask

  initial begin
    core_clk = 1'b0;
    rst_n    = 1'b0;
    cyc      = 1'b0;
    stb      = 1'b0;
    we       = 1'b0;
    adr      = '0;
    sel      = 4'h0;
    wdat     = 32'h0000_0000;
    allow    = 1'b0;
    xtal_run = 1'b0;
    do_reset(1'b0);
    t_regs();
    t_wdt();
    t_gate();
    t_slow();
    t_wdt();
    t_xtal();
    tally_and_finish();
  end
endmodule
